// >>> ofcs_pkg.sv
// Package of constants and types for the oscillator and clock select block.
// Assumes a single core clock domain and an APB register port.
package ofcs_pkg;
  // Register map and field layout of the oscillator control register.
  localparam logic [11:0] OSC_CTRL_OFFSET = 12'h000;
  localparam int          PLL_BIT         = 7;
  localparam int          FREQ_MSB        = 6;
  localparam int          FREQ_LSB        = 3;
  localparam int          GAP_BIT         = 2;
  localparam int          SEL_MSB         = 1;
  localparam int          SEL_LSB         = 0;
  localparam logic        PLL_RESET       = 1'b0;
  localparam logic [3:0]  FREQ_RESET      = 4'h7;
  localparam logic [1:0]  SEL_RESET       = 2'h0;
  // Cycles the system clock is held off before and after a switch.
  localparam int          GAP_CYCLES      = 4;

  // Frequency select codes.
  localparam logic [3:0] F_HF16M = 4'hf;
  localparam logic [3:0] F_HF8M  = 4'he;
  localparam logic [3:0] F_HF4M  = 4'hd;
  localparam logic [3:0] F_HF2M  = 4'hc;
  localparam logic [3:0] F_HF1M  = 4'hb;
  localparam logic [3:0] F_HF500 = 4'ha;
  localparam logic [3:0] F_HF250 = 4'h9;
  localparam logic [3:0] F_HF125 = 4'h8;
  localparam logic [3:0] F_MF500 = 4'h7;
  localparam logic [3:0] F_MF250 = 4'h6;
  localparam logic [3:0] F_MF125 = 4'h5;
  localparam logic [3:0] F_MF62  = 4'h4;
  localparam logic [3:0] F_HF31  = 4'h3;
  localparam logic [3:0] F_MF31  = 4'h2;

  // Resulting frequencies in hertz.
  localparam logic [24:0] HZ_32M  = 25'd32000000;
  localparam logic [24:0] HZ_16M  = 25'd16000000;
  localparam logic [24:0] HZ_8M   = 25'd8000000;
  localparam logic [24:0] HZ_4M   = 25'd4000000;
  localparam logic [24:0] HZ_2M   = 25'd2000000;
  localparam logic [24:0] HZ_1M   = 25'd1000000;
  localparam logic [24:0] HZ_500K = 25'd500000;
  localparam logic [24:0] HZ_250K = 25'd250000;
  localparam logic [24:0] HZ_125K = 25'd125000;
  localparam logic [24:0] HZ_62K5 = 25'd62500;
  localparam logic [24:0] HZ_31K2 = 25'd31250;
  localparam logic [24:0] HZ_31K  = 25'd31000;

  typedef enum logic [1:0] {
    SRC_CFG      = 2'b00,
    SRC_TIMER    = 2'b01,
    SRC_INTERNAL = 2'b10
  } ofcs_sys_src_t;

  typedef enum logic [1:0] {
    OSC_LF = 2'b00,
    OSC_MF = 2'b01,
    OSC_HF = 2'b10
  } ofcs_osc_t;

  typedef enum logic [1:0] {
    SEQ_IDLE     = 2'b00,
    SEQ_GATE_OFF = 2'b01,
    SEQ_SWAP     = 2'b10,
    SEQ_GATE_ON  = 2'b11
  } ofcs_seq_t;
endpackage : ofcs_pkg

// >>> ofcs_switch_seq.sv
// Break-before-make sequencer that hands a new clock selection over safely.
// Assumes a synchronised active-low reset in the core clock domain.
`timescale 1ns/100ps
`default_nettype none
module ofcs_switch_seq #(
  parameter int unsigned GAP_CYCLES = ofcs_pkg::GAP_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [6:0] req_in,
  output var  logic [6:0] applied_out,
  output var  logic       gate_en_out,
  output logic            busy_out
);
  localparam logic [3:0] GAP_M1 = 4'(GAP_CYCLES - 1);

  ofcs_pkg::ofcs_seq_t state;
  logic [3:0]          cnt;

  assign busy_out = (state != ofcs_pkg::SEQ_IDLE) || (req_in != applied_out);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ofcs_pkg::SEQ_IDLE;
      cnt   <= 4'h0;
    end else begin
      case (state)
        ofcs_pkg::SEQ_IDLE: begin
          cnt <= 4'h0;
          if (req_in != applied_out) begin
            state <= ofcs_pkg::SEQ_GATE_OFF;
          end
        end
        ofcs_pkg::SEQ_GATE_OFF: begin
          cnt <= cnt + 4'h1;
          if (cnt == GAP_M1) begin
            state <= ofcs_pkg::SEQ_SWAP;
          end
        end
        ofcs_pkg::SEQ_SWAP: begin
          cnt   <= 4'h0;
          state <= ofcs_pkg::SEQ_GATE_ON;
        end
        default: begin
          cnt <= cnt + 4'h1;
          if (cnt == GAP_M1) begin
            state <= ofcs_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // The selection changes only while the clock is gated off.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      applied_out <= {ofcs_pkg::PLL_RESET, ofcs_pkg::FREQ_RESET,
                      ofcs_pkg::SEL_RESET};
    end else if (state == ofcs_pkg::SEQ_SWAP) begin
      applied_out <= req_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_en_out <= 1'b1;
    end else if (state == ofcs_pkg::SEQ_IDLE && req_in != applied_out) begin
      gate_en_out <= 1'b0;
    end else if (state == ofcs_pkg::SEQ_GATE_ON && cnt == GAP_M1) begin
      gate_en_out <= 1'b1;
    end
  end

  sequence s_gate_low4;
    !gate_en_out [*4];
  endsequence

  sequence s_swap_done;
    $changed(applied_out) ##1 !gate_en_out;
  endsequence

  property p_gate_on_request;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state == ofcs_pkg::SEQ_IDLE && req_in != applied_out)
      |=> s_gate_low4;
  endproperty
  a_gate_on_request: assert property (p_gate_on_request)
    else $error("clock not gated before switch");

  property p_swap_gated;
    @(posedge clk_in) disable iff (!rst_n_in)
      $changed(applied_out) |-> !gate_en_out && $past(!gate_en_out)
      ##0 s_swap_done;
  endproperty
  a_swap_gated: assert property (p_swap_gated)
    else $error("selection changed with clock running");

  property p_regate_bound;
    @(posedge clk_in) disable iff (!rst_n_in)
      $fell(gate_en_out) |-> ##[9:12] gate_en_out;
  endproperty
  a_regate_bound: assert property (p_regate_bound)
    else $error("clock gate did not reopen in time");
endmodule : ofcs_switch_seq
`default_nettype wire

// >>> ofcs_top.sv
// Oscillator frequency and system clock selection with an APB register.
// Assumes the configuration word inputs are static after reset.
`timescale 1ns/100ps
`default_nettype none
module ofcs_top #(
  parameter int unsigned GAP_CYCLES = ofcs_pkg::GAP_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output var  logic [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        cfg_pll_force_in,
  input  wire logic [2:0]  cfg_osc_select_in,
  output var  logic        pll_active_out,
  output var  logic [1:0]  sys_src_out,
  output var  logic [2:0]  cfg_osc_select_out,
  output var  logic [1:0]  int_osc_out,
  output var  logic [24:0] int_freq_hz_out,
  output logic             clk_gate_en_out,
  output logic             switching_out
);
  logic        rst_meta;
  logic        rst_n;
  logic        sw_pll_enable;
  logic [3:0]  int_osc_freq_sel;
  logic [1:0]  sys_clk_select;
  logic [7:0]  ctrl_word;
  logic [6:0]  applied;
  logic        addr_hit;
  logic        wr_en;
  logic        pll_on;
  logic [24:0] next_freq;
  logic [1:0]  next_osc;
  logic [1:0]  next_src;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // APB slave: zero wait states, error on any other address.
  assign addr_hit    = (paddr_in == ofcs_pkg::OSC_CTRL_OFFSET);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_hit;
  assign wr_en       = psel_in && penable_in && pwrite_in && addr_hit;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sw_pll_enable    <= ofcs_pkg::PLL_RESET;
      int_osc_freq_sel <= ofcs_pkg::FREQ_RESET;
      sys_clk_select   <= ofcs_pkg::SEL_RESET;
    end else if (wr_en) begin
      sw_pll_enable    <= pwdata_in[ofcs_pkg::PLL_BIT];
      int_osc_freq_sel <= pwdata_in[ofcs_pkg::FREQ_MSB:ofcs_pkg::FREQ_LSB];
      sys_clk_select   <= pwdata_in[ofcs_pkg::SEL_MSB:ofcs_pkg::SEL_LSB];
    end
  end

  always_comb begin
    ctrl_word                                     = 8'h00;
    ctrl_word[ofcs_pkg::PLL_BIT]                  = sw_pll_enable;
    ctrl_word[ofcs_pkg::FREQ_MSB:ofcs_pkg::FREQ_LSB] = int_osc_freq_sel;
    ctrl_word[ofcs_pkg::GAP_BIT]                  = 1'b0;
    ctrl_word[ofcs_pkg::SEL_MSB:ofcs_pkg::SEL_LSB] = sys_clk_select;
  end

  // Read data is captured in the setup phase so it is stable in access.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= addr_hit ? {24'h00_0000, ctrl_word} : 32'h0000_0000;
    end
  end

  ofcs_switch_seq #(
    .GAP_CYCLES (GAP_CYCLES)
  ) u_seq (
    .clk_in      (core_clk_in),
    .rst_n_in    (rst_n),
    .req_in      ({sw_pll_enable, int_osc_freq_sel, sys_clk_select}),
    .applied_out (applied),
    .gate_en_out (clk_gate_en_out),
    .busy_out    (switching_out)
  );

  assign pll_on = cfg_pll_force_in || applied[6];

  always_comb begin
    next_osc  = ofcs_pkg::OSC_HF;
    next_freq = ofcs_pkg::HZ_31K;
    case (applied[5:2])
      ofcs_pkg::F_HF16M: next_freq = pll_on ? ofcs_pkg::HZ_32M
                                            : ofcs_pkg::HZ_16M;
      ofcs_pkg::F_HF8M:  next_freq = pll_on ? ofcs_pkg::HZ_32M
                                            : ofcs_pkg::HZ_8M;
      ofcs_pkg::F_HF4M:  next_freq = ofcs_pkg::HZ_4M;
      ofcs_pkg::F_HF2M:  next_freq = ofcs_pkg::HZ_2M;
      ofcs_pkg::F_HF1M:  next_freq = ofcs_pkg::HZ_1M;
      ofcs_pkg::F_HF500: next_freq = ofcs_pkg::HZ_500K;
      ofcs_pkg::F_HF250: next_freq = ofcs_pkg::HZ_250K;
      ofcs_pkg::F_HF125: next_freq = ofcs_pkg::HZ_125K;
      ofcs_pkg::F_HF31:  next_freq = ofcs_pkg::HZ_31K2;
      ofcs_pkg::F_MF500: begin
        next_osc  = ofcs_pkg::OSC_MF;
        next_freq = ofcs_pkg::HZ_500K;
      end
      ofcs_pkg::F_MF250: begin
        next_osc  = ofcs_pkg::OSC_MF;
        next_freq = ofcs_pkg::HZ_250K;
      end
      ofcs_pkg::F_MF125: begin
        next_osc  = ofcs_pkg::OSC_MF;
        next_freq = ofcs_pkg::HZ_125K;
      end
      ofcs_pkg::F_MF62: begin
        next_osc  = ofcs_pkg::OSC_MF;
        next_freq = ofcs_pkg::HZ_62K5;
      end
      ofcs_pkg::F_MF31: begin
        next_osc  = ofcs_pkg::OSC_MF;
        next_freq = ofcs_pkg::HZ_31K2;
      end
      default: begin
        next_osc  = ofcs_pkg::OSC_LF;
        next_freq = ofcs_pkg::HZ_31K;
      end
    endcase
  end

  always_comb begin
    if (applied[1]) begin
      next_src = ofcs_pkg::SRC_INTERNAL;
    end else if (applied[0]) begin
      next_src = ofcs_pkg::SRC_TIMER;
    end else begin
      next_src = ofcs_pkg::SRC_CFG;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pll_active_out     <= 1'b0;
      sys_src_out        <= ofcs_pkg::SRC_CFG;
      cfg_osc_select_out <= 3'h0;
      int_osc_out        <= ofcs_pkg::OSC_MF;
      int_freq_hz_out    <= ofcs_pkg::HZ_500K;
    end else begin
      pll_active_out     <= pll_on;
      sys_src_out        <= next_src;
      cfg_osc_select_out <= cfg_osc_select_in;
      int_osc_out        <= next_osc;
      int_freq_hz_out    <= next_freq;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  property p_force;
    cfg_pll_force_in |=> pll_active_out;
  endproperty
  a_force: assert property (p_force)
    else $error("forced PLL not active");

  property p_sw_pll;
    (!switching_out && $past(!switching_out) && !cfg_pll_force_in)
    |=> pll_active_out == $past(sw_pll_enable);
  endproperty
  a_sw_pll: assert property (p_sw_pll)
    else $error("PLL state differs from software bit");

  property p_high_taps;
    (applied[5:2] == ofcs_pkg::F_HF4M) |=> int_freq_hz_out == 25'd4000000;
  endproperty
  a_high_taps: assert property (p_high_taps)
    else $error("4 MHz tap wrong");

  property p_hf_div;
    (applied[5:2] == ofcs_pkg::F_HF31)
    |=> int_freq_hz_out == 25'd31250 && int_osc_out == ofcs_pkg::OSC_HF;
  endproperty
  a_hf_div: assert property (p_hf_div)
    else $error("divided high tap wrong");

  property p_mf_lf;
    (applied[5:3] == 3'h0)
    |=> int_freq_hz_out == 25'd31000 && int_osc_out == ofcs_pkg::OSC_LF;
  endproperty
  a_mf_lf: assert property (p_mf_lf)
    else $error("low frequency code wrong");

  property p_pll32;
    (applied[5:3] == 3'h7 && pll_on) |=> int_freq_hz_out == 25'd32000000;
  endproperty
  a_pll32: assert property (p_pll32)
    else $error("32 MHz not delivered with PLL");

  property p_src_sel;
    applied[1] |=> sys_src_out == ofcs_pkg::SRC_INTERNAL;
  endproperty
  a_src_sel: assert property (p_src_sel)
    else $error("internal source not selected");

  property p_cfg_src;
    (applied[1:0] == 2'h0)
    |=> sys_src_out == ofcs_pkg::SRC_CFG
        && cfg_osc_select_out == $past(cfg_osc_select_in);
  endproperty
  a_cfg_src: assert property (p_cfg_src)
    else $error("configuration source not followed");

  property p_reset_val;
    $rose(rst_n) |-> ctrl_word == 8'h38 && int_freq_hz_out == 25'd500000;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("reset value wrong");

  property p_bit2;
    $past(psel_in && !penable_in) |-> prdata_out[2] == 1'b0;
  endproperty
  a_bit2: assert property (p_bit2)
    else $error("bit 2 read as one");
endmodule : ofcs_top
`default_nettype wire

// >>> ofcs_tb_top.sv
// Self-checking bench for the oscillator and clock select block.
// Assumes the design checks its own timing rules with inline assertions.
`timescale 1ns/100ps
`default_nettype none
module ofcs_tb_top;
  localparam int unsigned GAP = 4;
  logic        core_clk_in = 1'b0;
  logic        arst_n_in   = 1'b0;
  logic        psel_in     = 1'b0;
  logic        penable_in  = 1'b0;
  logic        pwrite_in   = 1'b0;
  logic [11:0] paddr_in    = 12'h000;
  logic [31:0] pwdata_in   = 32'h0;
  logic        cfg_pll_force_in  = 1'b0;
  logic [2:0]  cfg_osc_select_in = 3'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        pll_active_out;
  logic [1:0]  sys_src_out;
  logic [2:0]  cfg_osc_select_out;
  logic [1:0]  int_osc_out;
  logic [24:0] int_freq_hz_out;
  logic        clk_gate_en_out;
  logic        switching_out;
  logic [7:0]  cur;
  logic [31:0] rd;
  logic        err;
  int          num_errors  = 0;
  int          checks_done = 0;

  ofcs_top #(.GAP_CYCLES(GAP)) u_dut (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cfg_pll_force_in(cfg_pll_force_in),
    .cfg_osc_select_in(cfg_osc_select_in),
    .pll_active_out(pll_active_out), .sys_src_out(sys_src_out),
    .cfg_osc_select_out(cfg_osc_select_out), .int_osc_out(int_osc_out),
    .int_freq_hz_out(int_freq_hz_out), .clk_gate_en_out(clk_gate_en_out),
    .switching_out(switching_out));

  always #25 core_clk_in = ~core_clk_in;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  function automatic logic [24:0] exp_hz(input logic [3:0] c, input logic p);
    case (c)
      4'hf: exp_hz = p ? ofcs_pkg::HZ_32M : ofcs_pkg::HZ_16M;
      4'he: exp_hz = p ? ofcs_pkg::HZ_32M : ofcs_pkg::HZ_8M;
      4'hd: exp_hz = ofcs_pkg::HZ_4M;
      4'hc: exp_hz = ofcs_pkg::HZ_2M;
      4'hb: exp_hz = ofcs_pkg::HZ_1M;
      4'ha, 4'h7: exp_hz = ofcs_pkg::HZ_500K;
      4'h9, 4'h6: exp_hz = ofcs_pkg::HZ_250K;
      4'h8, 4'h5: exp_hz = ofcs_pkg::HZ_125K;
      4'h4: exp_hz = ofcs_pkg::HZ_62K5;
      4'h3, 4'h2: exp_hz = ofcs_pkg::HZ_31K2;
      default: exp_hz = ofcs_pkg::HZ_31K;
    endcase
  endfunction : exp_hz

  function automatic logic [1:0] exp_osc(input logic [3:0] c);
    if (c >= 4'h8 || c == 4'h3) begin
      exp_osc = 2'b10;
    end else if (c >= 4'h4 || c == 4'h2) begin
      exp_osc = 2'b01;
    end else begin
      exp_osc = 2'b00;
    end
  endfunction : exp_osc

  // Waits out a clock switch and counts gated cycles.
  task automatic wait_switch(input logic chg);
    int n;
    int low;
    n = 0;
    low = 0;
    @(posedge core_clk_in);
    #1;
    if (chg) chk(switching_out, 1'b1);
    while (switching_out !== 1'b0 && n < 200) begin
      if (clk_gate_en_out !== 1'b1) low++;
      @(posedge core_clk_in);
      #1;
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      finish_test();
    end
    // Gate is low for the off gap, the swap cycle and the whole on gap.
    if (chg) chk(low, 2 * GAP + 1);
    chk(clk_gate_en_out, 1'b1);
  endtask : wait_switch

  task automatic check_outputs(input logic [7:0] v);
    logic p;
    p = cfg_pll_force_in | v[7];
    chk(pll_active_out, p);
    chk(int_freq_hz_out, exp_hz(v[6:3], p));
    chk(int_osc_out, exp_osc(v[6:3]));
    chk(sys_src_out, v[1] ? 2'b10 : {1'b0, v[0]});
    chk(cfg_osc_select_out, cfg_osc_select_in);
    apb(1'b1 ^ 1'b1, 12'h000, 32'h0, rd, err);
    chk(rd, {24'h0, v & 8'hfb});
  endtask : check_outputs

  task automatic run_case(input logic [7:0] v);
    logic chg;
    chg = ((v & 8'hfb) != cur);
    apb(1'b1, 12'h000, {24'h0, v}, rd, err);
    chk(err, 1'b0);
    cur = v & 8'hfb;
    wait_switch(chg);
    check_outputs(v);
  endtask : run_case

  initial begin
    logic [7:0] v;
    cur = 8'h38;
    rd = $urandom(38);
    repeat (5) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1;
    check_outputs(8'h38);
    $display("test reset done");
    apb(1'b1, 12'h004, 32'hffff_ffff, rd, err);
    chk(err, 1'b1);
    apb(1'b0, 12'h000 | ({$urandom} % 12'hfff + 12'h1), 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    check_outputs(8'h38);
    $display("test unmapped done");
    for (int c = 0; c < 16; c++) begin
      // The PLL bit follows c[1] so both top codes are seen with it set.
      v = {c[1], c[3:0], 1'b1, 2'($urandom)};
      cfg_osc_select_in <= 3'($urandom);
      run_case(v);
    end
    $display("test codes done");
    cfg_pll_force_in <= 1'b1;
    foreach (v[i]) begin
      if (i < 3) run_case({1'b0, 4'hf - 4'(i), 3'(i)});
    end
    cfg_pll_force_in <= 1'b0;
    run_case(8'h70);
    $display("test force done");
    repeat (20) begin
      cfg_pll_force_in <= 1'($urandom);
      cfg_osc_select_in <= 3'($urandom);
      run_case(8'($urandom));
    end
    $display("test random done");
    apb(1'b1, 12'h000, 32'h0000_00f9, rd, err);
    v = 8'h2a;
    apb(1'b1, 12'h000, {24'h0, v}, rd, err);
    cur = v;
    wait_switch(1'b0);
    repeat (3 * GAP + 4) @(posedge core_clk_in);
    #1;
    check_outputs(v);
    $display("test back to back done");
    finish_test();
  end
endmodule : ofcs_tb_top
`default_nettype wire
